/* rtl/xcs_pkg.sv */
/*
 * Shared constants and carrier types for the transceiver control and status timing block.
 * Assumes a single 100 MHz core clock; all times below are converted to cycles of that clock.
 */
package xcs_pkg;

   // ==========================================================================
   // Clock
   // ==========================================================================
   localparam int unsigned XCS_CLK_MHZ = 100;
   localparam int unsigned XCS_CLK_PERIOD_NS = 10;

   // ==========================================================================
   // Times and derived cycle counts
   // ==========================================================================
   localparam int unsigned XCS_T_FAULT_RESET_US = 10;
   localparam int unsigned XCS_FAULT_RESET_CYC = XCS_T_FAULT_RESET_US * XCS_CLK_MHZ;
   localparam int unsigned XCS_T_REJECT_NS = 4500;
   localparam int unsigned XCS_REJECT_CYC = XCS_T_REJECT_NS / XCS_CLK_PERIOD_NS;
   localparam int unsigned XCS_T_TICK_US = 500;
   localparam int unsigned XCS_TICK_CYC = XCS_T_TICK_US * XCS_CLK_MHZ;
   localparam int unsigned XCS_T_INIT2_MS = 200;
   localparam int unsigned XCS_INIT2_CYC = XCS_T_INIT2_MS * 1000 * XCS_CLK_MHZ;
   localparam int unsigned XCS_T_DATA_MS = 400;
   localparam int unsigned XCS_DATA_CYC = XCS_T_DATA_MS * 1000 * XCS_CLK_MHZ;
   localparam int unsigned XCS_T_NVWR_MS = 13;
   localparam int unsigned XCS_NVWR_CYC = XCS_T_NVWR_MS * 1000 * XCS_CLK_MHZ;

   // ==========================================================================
   // Widths and limits
   // ==========================================================================
   localparam int unsigned XCS_FLT_W = 3;
   localparam int unsigned XCS_CNT_W = 26;
   localparam int unsigned XCS_FILT_W = 9;
   localparam int unsigned XCS_OFFCNT_W = 10;
   localparam logic [2:0] XCS_WR_MIN_BYTES = 3'h1;
   localparam logic [2:0] XCS_WR_MAX_BYTES = 3'h4;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [1:0]
   {
      XCS_ST_INIT = 2'b00,
      XCS_ST_ON = 2'b01,
      XCS_ST_OFF = 2'b10
   } xcs_state_e;

   typedef struct packed
   {
      logic tx_fault;
      logic tx_off;
      logic rx_loss;
      logic rate_sel;
   } xcs_status_s;

   typedef struct packed
   {
      logic soft_tx_off;
      logic soft_rate_sel;
      logic irq_set;
   } xcs_ctrl_s;

endpackage : xcs_pkg

/* rtl/xcs_glitch_filter.sv */
/*
 * Per-bit synchroniser and glitch filter for comparator outputs.
 * Assumes raw inputs may be asynchronous; output changes only after the input held its new level
 * for more than the reject time.
 */
`timescale 1ns/100ps
module xcs_glitch_filter
   import xcs_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic [WIDTH-1:0] i_raw,
   output logic [WIDTH-1:0] o_clean
);

   // ==========================================================================
   // One synchroniser and stability counter per bit
   // ==========================================================================
   for (genvar b = 0; b < WIDTH; b++)
   begin : g_bit
      logic s1_q;
      logic s2_q;
      logic clean_q;
      logic clean_d;
      logic [XCS_FILT_W-1:0] cnt_q;
      logic [XCS_FILT_W-1:0] cnt_d;

      always_comb
      begin
         clean_d = clean_q;
         cnt_d = '0;
         if (s2_q != clean_q)
         begin
            // A level held for more cycles than the reject time is taken; shorter pulses are dropped.
            if (cnt_q == XCS_FILT_W'(XCS_REJECT_CYC))
            begin
               clean_d = s2_q;
            end
            else
            begin
               cnt_d = cnt_q + XCS_FILT_W'(1);
            end
         end
      end

      always_ff @(posedge i_core_clk)
      begin
         if (!i_rstn)
         begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            clean_q <= 1'b0;
            cnt_q <= '0;
         end
         else
         begin
            s1_q <= i_raw[b];
            s2_q <= s1_q;
            clean_q <= clean_d;
            cnt_q <= cnt_d;
         end
      end

      assign o_clean[b] = clean_q;
   end

endmodule : xcs_glitch_filter

/* rtl/xcs_tick_div.sv */
/*
 * Divider producing a one-cycle enable pulse every PERIOD core clock cycles.
 * Assumes the core clock is the only clock.
 */
`timescale 1ns/100ps
module xcs_tick_div
   import xcs_pkg::*;
#(
   parameter int unsigned PERIOD = XCS_TICK_CYC
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   output logic o_tick
);

   logic [XCS_CNT_W-1:0] cnt_q;
   logic [XCS_CNT_W-1:0] cnt_d;
   logic tick_q;
   logic tick_d;

   // ==========================================================================
   // Free-running count
   // ==========================================================================
   always_comb
   begin
      tick_d = 1'b0;
      cnt_d = cnt_q + XCS_CNT_W'(1);
      if (cnt_q == XCS_CNT_W'(PERIOD - 1))
      begin
         cnt_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign o_tick = tick_q;

endmodule : xcs_tick_div

/* rtl/xcs_ctrl_status.sv */
/*
 * Control and status timing of an optical transceiver manager: laser enable and power loop
 * start-up, transmit-fault latch and clear, signal-loss report, pin to status propagation,
 * fault masking after enable and the nonvolatile write busy window seen by the serial bus.
 * Assumes control pins are synchronous to the core clock and that the serial bus engine
 * reports address matches and write stops as one-cycle pulses.
 */
`timescale 1ns/100ps

module xcs_ctrl_status
   import xcs_pkg::*;
#(
   parameter int unsigned P_INIT_CYC = XCS_INIT2_CYC,
   parameter int unsigned P_DATA_CYC = XCS_DATA_CYC,
   parameter int unsigned P_TICK_CYC = XCS_TICK_CYC,
   parameter int unsigned P_NVWR_CYC = XCS_NVWR_CYC
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_transmit_off_in,
   input wire logic i_rate_select_in,
   input wire logic [XCS_FLT_W-1:0] i_fault_src,
   input wire logic i_signal_loss_raw,
   input wire xcs_ctrl_s i_ctrl,
   input wire logic [7:0] i_fault_mask_interval,
   input wire logic [XCS_FLT_W-1:0] i_fault_source_mask,
   input wire logic i_wr_stop,
   input wire logic [2:0] i_wr_bytes,
   input wire logic i_addr_match,
   output logic o_transmit_fault_out,
   output logic o_receive_signal_loss_out,
   output logic o_rate_select_out,
   output logic o_irq_n,
   output logic o_laser_drive_en,
   output logic o_laser_power_loop_en,
   output logic o_data_ready,
   output xcs_status_s o_status,
   output logic o_nv_busy,
   output logic o_addr_ack,
   output logic o_addr_nack
);

   // ==========================================================================
   // Filtered comparators and suppression tick
   // ==========================================================================
   logic [XCS_FLT_W:0] filt_clean;
   logic tick;

   xcs_glitch_filter #(
      .WIDTH(XCS_FLT_W + 1)
   ) u_filter (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_raw({i_signal_loss_raw, i_fault_src}),
      .o_clean(filt_clean)
   );

   xcs_tick_div #(
      .PERIOD(P_TICK_CYC)
   ) u_tick (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .o_tick(tick)
   );

   // ==========================================================================
   // State
   // ==========================================================================
   xcs_state_e state_q;
   xcs_state_e state_d;
   logic [XCS_CNT_W-1:0] init_cnt_q;
   logic [XCS_CNT_W-1:0] init_cnt_d;
   logic [XCS_CNT_W-1:0] data_cnt_q;
   logic [XCS_CNT_W-1:0] data_cnt_d;
   logic [7:0] mask_cnt_q;
   logic [7:0] mask_cnt_d;
   logic [XCS_OFFCNT_W-1:0] off_cnt_q;
   logic [XCS_OFFCNT_W-1:0] off_cnt_d;
   logic fault_q;
   logic fault_d;
   logic loop_en_q;
   logic loop_en_d;
   logic drive_q;
   logic drive_d;
   logic data_rdy_q;
   logic data_rdy_d;
   logic fault_out_q;
   logic fault_out_d;
   logic los_q;
   logic los_d;
   logic rsel_q;
   logic rsel_d;
   logic irq_n_q;
   logic irq_n_d;
   xcs_status_s status_q;
   xcs_status_s status_d;
   logic tx_off;
   logic fault_set;
   logic fault_clr;

   assign tx_off = i_transmit_off_in | i_ctrl.soft_tx_off;
   // Sources are only looked at once the transmitter is on and the mask window has run out.
   assign fault_set = (|(filt_clean[XCS_FLT_W-1:0] & i_fault_source_mask))
                      & (state_q == XCS_ST_ON) & (mask_cnt_q == 8'h00);
   assign fault_clr = (off_cnt_q == XCS_OFFCNT_W'(XCS_FAULT_RESET_CYC));

   // ==========================================================================
   // Laser start-up and enable sequence
   // ==========================================================================
   always_comb
   begin
      state_d = state_q;
      init_cnt_d = init_cnt_q;
      mask_cnt_d = mask_cnt_q;
      loop_en_d = loop_en_q;
      if ((mask_cnt_q != 8'h00) && tick)
      begin
         mask_cnt_d = mask_cnt_q - 8'h01;
      end
      case (state_q)
         XCS_ST_INIT:
         begin
            init_cnt_d = init_cnt_q + XCS_CNT_W'(1);
            if (init_cnt_q == XCS_CNT_W'(P_INIT_CYC - 1))
            begin
               loop_en_d = 1'b1;
               mask_cnt_d = i_fault_mask_interval;
               state_d = tx_off ? XCS_ST_OFF : XCS_ST_ON;
            end
         end
         XCS_ST_ON:
         begin
            if (tx_off)
            begin
               state_d = XCS_ST_OFF;
            end
         end
         XCS_ST_OFF:
         begin
            if (!tx_off)
            begin
               state_d = XCS_ST_ON;
               mask_cnt_d = i_fault_mask_interval;
            end
         end
         default:
         begin
            state_d = XCS_ST_INIT;
         end
      endcase
   end

   // ==========================================================================
   // Fault latch, clear timer and data ready
   // ==========================================================================
   always_comb
   begin
      off_cnt_d = '0;
      if (tx_off)
      begin
         off_cnt_d = fault_clr ? off_cnt_q : off_cnt_q + XCS_OFFCNT_W'(1);
      end
      // A new fault in the clearing cycle wins over the clear.
      fault_d = fault_set | (fault_q & ~fault_clr);
      data_cnt_d = data_cnt_q;
      data_rdy_d = data_rdy_q;
      if (!data_rdy_q)
      begin
         data_cnt_d = data_cnt_q + XCS_CNT_W'(1);
         if (data_cnt_q == XCS_CNT_W'(P_DATA_CYC - 1))
         begin
            data_rdy_d = 1'b1;
         end
      end
   end

   // ==========================================================================
   // Pin and status outputs
   // ==========================================================================
   always_comb
   begin
      drive_d = (state_d == XCS_ST_ON) & ~fault_d;
      // The fault pin reads active until start-up finishes.
      fault_out_d = fault_d | (state_d == XCS_ST_INIT);
      los_d = filt_clean[XCS_FLT_W];
      rsel_d = i_ctrl.soft_rate_sel;
      irq_n_d = ~i_ctrl.irq_set;
      status_d.tx_fault = fault_out_d;
      status_d.tx_off = i_transmit_off_in;
      status_d.rx_loss = filt_clean[XCS_FLT_W];
      status_d.rate_sel = i_rate_select_in;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         state_q <= XCS_ST_INIT;
         init_cnt_q <= '0;
         data_cnt_q <= '0;
         mask_cnt_q <= 8'h00;
         off_cnt_q <= '0;
         fault_q <= 1'b0;
         loop_en_q <= 1'b0;
         drive_q <= 1'b0;
         data_rdy_q <= 1'b0;
         fault_out_q <= 1'b1;
         los_q <= 1'b0;
         rsel_q <= 1'b0;
         irq_n_q <= 1'b1;
         status_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         init_cnt_q <= init_cnt_d;
         data_cnt_q <= data_cnt_d;
         mask_cnt_q <= mask_cnt_d;
         off_cnt_q <= off_cnt_d;
         fault_q <= fault_d;
         loop_en_q <= loop_en_d;
         drive_q <= drive_d;
         data_rdy_q <= data_rdy_d;
         fault_out_q <= fault_out_d;
         los_q <= los_d;
         rsel_q <= rsel_d;
         irq_n_q <= irq_n_d;
         status_q <= status_d;
      end
   end

   // ==========================================================================
   // Nonvolatile programming busy window
   // ==========================================================================
   logic [XCS_CNT_W-1:0] nv_cnt_q;
   logic [XCS_CNT_W-1:0] nv_cnt_d;
   logic nv_busy_q;
   logic nv_busy_d;
   logic ack_q;
   logic ack_d;
   logic nack_q;
   logic nack_d;

   always_comb
   begin
      nv_cnt_d = nv_cnt_q;
      nv_busy_d = nv_busy_q;
      if (nv_busy_q)
      begin
         nv_cnt_d = nv_cnt_q + XCS_CNT_W'(1);
         if (nv_cnt_q == XCS_CNT_W'(P_NVWR_CYC - 1))
         begin
            nv_busy_d = 1'b0;
         end
      end
      else if (i_wr_stop && (i_wr_bytes >= XCS_WR_MIN_BYTES) && (i_wr_bytes <= XCS_WR_MAX_BYTES))
      begin
         nv_busy_d = 1'b1;
         nv_cnt_d = '0;
      end
      ack_d = i_addr_match & ~nv_busy_q;
      nack_d = i_addr_match & nv_busy_q;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         nv_cnt_q <= '0;
         nv_busy_q <= 1'b0;
         ack_q <= 1'b0;
         nack_q <= 1'b0;
      end
      else
      begin
         nv_cnt_q <= nv_cnt_d;
         nv_busy_q <= nv_busy_d;
         ack_q <= ack_d;
         nack_q <= nack_d;
      end
   end

   assign o_transmit_fault_out = fault_out_q;
   assign o_receive_signal_loss_out = los_q;
   assign o_rate_select_out = rsel_q;
   assign o_irq_n = irq_n_q;
   assign o_laser_drive_en = drive_q;
   assign o_laser_power_loop_en = loop_en_q;
   assign o_data_ready = data_rdy_q;
   assign o_status = status_q;
   assign o_nv_busy = nv_busy_q;
   assign o_addr_ack = ack_q;
   assign o_addr_nack = nack_q;

endmodule : xcs_ctrl_status

/* verif/xcs_ctrl_status_assertions.sv */
/* Port-level checker for xcs_ctrl_status.
 * Assumes one core clock and synchronous active-low reset; attached by bind. */
`timescale 1ns/100ps
module xcs_ctrl_status_assertions
   import xcs_pkg::*;
#(
   parameter int unsigned P_INIT_CYC = XCS_INIT2_CYC,
   parameter int unsigned P_DATA_CYC = XCS_DATA_CYC,
   parameter int unsigned P_NVWR_CYC = XCS_NVWR_CYC
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_transmit_off_in,
   input wire logic i_rate_select_in,
   input wire logic i_signal_loss_raw,
   input wire xcs_ctrl_s i_ctrl,
   input wire logic i_wr_stop,
   input wire logic [2:0] i_wr_bytes,
   input wire logic i_addr_match,
   input wire logic o_transmit_fault_out,
   input wire logic o_receive_signal_loss_out,
   input wire logic o_rate_select_out,
   input wire logic o_irq_n,
   input wire logic o_laser_drive_en,
   input wire logic o_laser_power_loop_en,
   input wire logic o_data_ready,
   input wire xcs_status_s o_status,
   input wire logic o_nv_busy,
   input wire logic o_addr_ack,
   input wire logic o_addr_nack
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   // ==========================================================================
   // Helper counters
   // ==========================================================================
   int unsigned up_cnt;
   int unsigned busy_cnt;
   int unsigned loss_cnt;
   logic loss_q;
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         up_cnt <= 0;
         busy_cnt <= 0;
         loss_cnt <= 0;
         loss_q <= 1'b0;
      end
      else
      begin
         up_cnt <= (up_cnt < 1000000) ? up_cnt + 1 : up_cnt;
         busy_cnt <= o_nv_busy ? busy_cnt + 1 : 0;
         loss_q <= i_signal_loss_raw;
         loss_cnt <= (i_signal_loss_raw != loss_q) ? 0 : ((loss_cnt < 1000) ? loss_cnt + 1 : loss_cnt);
      end
   end
   // ==========================================================================
   // Properties
   // ==========================================================================
   a_drive_off_fast: assert property (i_transmit_off_in |=> !o_laser_drive_en)
      else $error("laser drive stayed on with disable high");
   a_init_loop: assert property (up_cnt >= P_INIT_CYC + 2 |-> o_laser_power_loop_en)
      else $error("power loop late after reset");
   a_init_fault: assert property (!o_laser_power_loop_en |-> o_transmit_fault_out)
      else $error("fault pin low before start-up done");
   a_data_ready: assert property (up_cnt >= P_DATA_CYC + 2 |-> o_data_ready)
      else $error("monitor data late");
   a_status_in: assert property ($past(i_rstn) |-> o_status.tx_off == $past(i_transmit_off_in)
      && o_status.rate_sel == $past(i_rate_select_in))
      else $error("status bits do not follow pins");
   a_ctrl_out: assert property ($past(i_rstn) |-> o_rate_select_out == $past(i_ctrl.soft_rate_sel)
      && o_irq_n == !$past(i_ctrl.irq_set))
      else $error("output pins do not follow control bits");
   a_nv_start: assert property (i_wr_stop && i_wr_bytes >= XCS_WR_MIN_BYTES
      && i_wr_bytes <= XCS_WR_MAX_BYTES && !o_nv_busy |=> o_nv_busy)
      else $error("write stop did not start programming");
   a_nv_bound: assert property (busy_cnt <= P_NVWR_CYC)
      else $error("programming cycle too long");
   a_busy_nack: assert property (i_addr_match && o_nv_busy |=> o_addr_nack && !o_addr_ack)
      else $error("address answered while busy");
   a_idle_ack: assert property (i_addr_match && !o_nv_busy |=> o_addr_ack && !o_addr_nack)
      else $error("address not acknowledged when idle");
   a_loss_filter: assert property ($changed(o_receive_signal_loss_out) |-> loss_cnt >= XCS_REJECT_CYC
      && o_receive_signal_loss_out == i_signal_loss_raw)
      else $error("loss output moved on a short pulse");
   a_loss_follow: assert property (loss_cnt == 600 |-> o_receive_signal_loss_out == i_signal_loss_raw)
      else $error("loss output did not follow input");
endmodule : xcs_ctrl_status_assertions

bind xcs_ctrl_status xcs_ctrl_status_assertions #(.P_INIT_CYC(P_INIT_CYC), .P_DATA_CYC(P_DATA_CYC),
   .P_NVWR_CYC(P_NVWR_CYC)) xcs_ctrl_status_assertions_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
   .i_transmit_off_in(i_transmit_off_in), .i_rate_select_in(i_rate_select_in), .i_ctrl(i_ctrl),
   .i_signal_loss_raw(i_signal_loss_raw), .i_wr_stop(i_wr_stop), .i_wr_bytes(i_wr_bytes),
   .i_addr_match(i_addr_match), .o_transmit_fault_out(o_transmit_fault_out), .o_irq_n(o_irq_n),
   .o_receive_signal_loss_out(o_receive_signal_loss_out), .o_rate_select_out(o_rate_select_out),
   .o_laser_drive_en(o_laser_drive_en), .o_laser_power_loop_en(o_laser_power_loop_en),
   .o_data_ready(o_data_ready), .o_status(o_status), .o_nv_busy(o_nv_busy), .o_addr_ack(o_addr_ack),
   .o_addr_nack(o_addr_nack));

/* verif/xcs_host_model.sv */
/* Behavioural serial-bus host: ends a write, then polls the address until acknowledged.
 * Assumes answers arrive one edge after the address pulse. */
`timescale 1ns/100ps
module xcs_host_model
   import xcs_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_go,
   input wire logic [2:0] i_bytes,
   input wire logic i_ack,
   input wire logic i_nack,
   output logic o_wr_stop,
   output logic [2:0] o_wr_bytes,
   output logic o_addr_match,
   output logic o_idle,
   output int o_nacks
);
   logic acked;
   initial
   begin
      o_wr_stop = 1'b0;
      o_wr_bytes = 3'h0;
      o_addr_match = 1'b0;
      o_idle = 1'b1;
      o_nacks = 0;
   end
   always
   begin
      @(posedge i_core_clk);
      if (i_go)
      begin
         o_idle <= 1'b0;
         o_nacks <= 0;
         o_wr_stop <= 1'b1;
         o_wr_bytes <= i_bytes;
         @(posedge i_core_clk);
         o_wr_stop <= 1'b0;
         // The count is only valid with the stop pulse, so it is scrambled afterwards.
         o_wr_bytes <= ~i_bytes;
         acked = 1'b0;
         for (int n = 0; n < 400 && !acked; n++)
         begin
            repeat (3) @(posedge i_core_clk);
            o_addr_match <= 1'b1;
            @(posedge i_core_clk);
            o_addr_match <= 1'b0;
            @(posedge i_core_clk);
            acked = i_ack;
            if (i_nack)
               o_nacks <= o_nacks + 1;
         end
         o_idle <= 1'b1;
      end
   end
endmodule : xcs_host_model

/* verif/tb_top.sv */
/* Self-checking bench for xcs_ctrl_status with shortened counts.
 * Assumes the checker is bound to the design and the host model drives the bus pulses. */
`timescale 1ns/100ps
module tb_top
   import xcs_pkg::*;
;
   localparam int unsigned LP_INIT = 100;
   localparam int unsigned LP_DATA = 200;
   localparam int unsigned LP_NVWR = 50;
   logic clk, rstn, toff, rate_select_in, lraw, wstop, am, go, hidle, loss_seen, busy_seen;
   logic [2:0] fsrc, fsm, wbytes, hb;
   logic [7:0] fmi;
   xcs_ctrl_s ctrl;
   xcs_status_s st;
   logic fault, loss, rout, irqn, drive, loop, rdy, busy, ack, nack;
   int error_cnt, cmp_count, seed, k, d, nacks;
   logic [31:0] v;
   int dl[4] = '{450, 470, 100, 900};
   logic [2:0] wb[4] = '{3'h1, 3'h4, 3'h0, 3'h5};

   xcs_ctrl_status #(.P_INIT_CYC(LP_INIT), .P_DATA_CYC(LP_DATA), .P_TICK_CYC(10), .P_NVWR_CYC(LP_NVWR))
   xcs_ctrl_status_i (.i_core_clk(clk), .i_rstn(rstn), .i_transmit_off_in(toff), .i_rate_select_in(rate_select_in),
      .i_fault_src(fsrc), .i_signal_loss_raw(lraw), .i_ctrl(ctrl), .i_fault_mask_interval(fmi),
      .i_fault_source_mask(fsm), .i_wr_stop(wstop), .i_wr_bytes(wbytes), .i_addr_match(am),
      .o_transmit_fault_out(fault), .o_receive_signal_loss_out(loss), .o_rate_select_out(rout),
      .o_irq_n(irqn), .o_laser_drive_en(drive), .o_laser_power_loop_en(loop), .o_data_ready(rdy),
      .o_status(st), .o_nv_busy(busy), .o_addr_ack(ack), .o_addr_nack(nack));
   xcs_host_model xcs_host_model_i (.i_core_clk(clk), .i_go(go), .i_bytes(hb), .i_ack(ack), .i_nack(nack),
      .o_wr_stop(wstop), .o_wr_bytes(wbytes), .o_addr_match(am), .o_idle(hidle), .o_nacks(nacks));

   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      if (loss === 1'b1)
         loss_seen <= 1'b1;
      if (busy === 1'b1)
         busy_seen <= 1'b1;
   end

   function automatic logic loss_exp(input int len);
      return len > XCS_REJECT_CYC;
   endfunction : loss_exp
   function automatic logic nv_exp(input logic [2:0] n);
      return n >= XCS_WR_MIN_BYTES && n <= XCS_WR_MAX_BYTES;
   endfunction : nv_exp
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   initial
   begin
      seed = 32'hf6b1;
      {clk, rstn, toff, rate_select_in, lraw, go, loss_seen, busy_seen} = '0;
      {fsrc, hb, ctrl} = '0;
      fmi = 8'hc8;
      fsm = 3'h7;
      cyc(12);
      chk("reset fault", fault, 1'b1);
      chk("reset irq", irqn, 1'b1);
      rstn <= 1'b1;
      for (k = 0; k < LP_DATA + 5 && rdy !== 1'b1; k++)
         @(posedge clk);
      chk("loop on", loop, 1'b1);
      chk("data ready", rdy, 1'b1);
      chk("init fault", fault, 1'b0);
      chk("init drive", drive, 1'b1);
      $display("test init done");
      cyc(2000);
      fsrc <= 3'h1;
      cyc(400);
      fsrc <= 3'h0;
      cyc(600);
      chk("glitch", fault, 1'b0);
      fsm <= 3'h6;
      fsrc <= 3'h1;
      cyc(600);
      fsrc <= 3'h0;
      // The filtered source lingers for the reject time, so it is unmasked only once it has settled.
      cyc(600);
      fsm <= 3'h7;
      cyc(10);
      chk("masked source", fault, 1'b0);
      toff <= 1'b1;
      cyc(2);
      chk("drive off", drive, 1'b0);
      toff <= 1'b0;
      cyc(2);
      chk("drive on", drive, 1'b1);
      fsrc <= 3'h2;
      cyc(600);
      fsrc <= 3'h0;
      cyc(10);
      chk("mask window", fault, 1'b0);
      cyc(2000);
      fsrc <= 3'h4;
      for (k = 0; k < 9500 && fault !== 1'b1; k++)
         @(posedge clk);
      chk("fault set", fault, 1'b1);
      chk("fault drive", drive, 1'b0);
      cyc(2);
      chk("fault status", st.tx_fault, 1'b1);
      {fsrc, toff} <= {3'h0, 1'b1};
      cyc(500);
      toff <= 1'b0;
      cyc(5);
      chk("short clear", fault, 1'b1);
      toff <= 1'b1;
      cyc(1010);
      toff <= 1'b0;
      cyc(3);
      chk("fault clear", fault, 1'b0);
      chk("drive back", drive, 1'b1);
      $display("test fault done");
      for (int i = 0; i < 6; i++)
      begin
         d = (i < 4) ? dl[i] : 100 + ($unsigned($random(seed)) % 800);
         if (d > 450 && d < 460)
            d = 500;
         {loss_seen, lraw} <= 2'b01;
         cyc(d);
         chk("status loss", st.rx_loss, loss_exp(d));
         lraw <= 1'b0;
         cyc(700);
         chk("loss seen", loss_seen, loss_exp(d));
         chk("loss clear", loss, 1'b0);
      end
      $display("test loss done");
      for (int i = 0; i < 8; i++)
      begin
         v = $random(seed);
         {toff, rate_select_in, ctrl} <= v[4:0];
         cyc(2);
         chk("status off", st.tx_off, v[4]);
         chk("status rate", st.rate_sel, v[3]);
         chk("rate out", rout, v[1]);
         chk("irq", irqn, !v[0]);
      end
      {toff, ctrl} <= '0;
      $display("test pins done");
      for (int i = 0; i < 5; i++)
      begin
         hb <= (i < 4) ? wb[i] : 3'($unsigned($random(seed)) % 4 + 1);
         {busy_seen, go} <= 2'b01;
         cyc(1);
         go <= 1'b0;
         cyc(1);
         for (k = 0; k < 3000 && hidle !== 1'b1; k++)
            @(posedge clk);
         chk("nv done", hidle, 1'b1);
         chk("nv busy", busy_seen, nv_exp(hb));
         chk("nv nack", nacks > 0, nv_exp(hb));
      end
      $display("test nv done");
      end_of_test();
   end
endmodule : tb_top
